/* File: pkg/ccrc_cfg_if.sv */
// decoded clock configuration passed from decoder to phase generator
`timescale 1ns/1ps
interface ccrc_cfg_if;
  ccrc_pkg::ccrc_ratio_e ratio;
  logic [1:0]            mult;
  logic                  bypass;
  logic                  clkOff;
  logic                  unsup;
  modport dec (output ratio, output mult, output bypass, output clkOff, output unsup);
  modport gen (input ratio, input mult, input bypass, input clkOff, input unsup);
endinterface : ccrc_cfg_if

/* File: pkg/ccrc_pkg.sv */
// constants and types for the core clock ratio configuration block
package ccrc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ    = 50;
  localparam int SETTLE_NS  = 100;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int FRAME_CYC  = 12;
  localparam int HALF_1_1   = 6;
  localparam int HALF_2_1   = 3;
  localparam int HALF_3_1   = 2;
  localparam int HALF_3_2   = 4;
  // ---------------------------------------------------------------
  // select codes and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_BYPASS = 4'h3;
  localparam logic [3:0] CODE_OFF    = 4'hf;
  localparam logic [1:0] RF_1_1      = 2'h0;
  localparam logic [1:0] RF_2_1      = 2'h1;
  localparam logic [1:0] RF_3_1      = 2'h2;
  localparam logic [1:0] RF_3_2      = 2'h3;
  localparam logic [1:0] MF_X2       = 2'h0;
  localparam logic [1:0] MF_X4       = 2'h1;
  localparam logic [1:0] MF_X8       = 2'h2;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_STATUS  = 5'h04;
  localparam logic [4:0] OFS_TXDATA  = 5'h08;
  localparam logic [4:0] OFS_RXDATA  = 5'h0c;
  localparam logic [4:0] OFS_CORECNT = 5'h10;
  localparam int CTRL_TCLK_EN = 0;
  localparam int ST_BYPASS    = 8;
  localparam int ST_OFF       = 9;
  localparam int ST_UNSUP     = 10;
  localparam int ST_VALID     = 11;
  localparam int ST_PINCHG    = 12;
  localparam logic CTRL_RST   = 1'b1;
  typedef enum logic [1:0] {RATIO_1_1, RATIO_2_1, RATIO_3_1, RATIO_3_2} ccrc_ratio_e;
endpackage : ccrc_pkg

/* File: sim/ccrc_board_model.sv */
// board side model: strap pins and bus input data
`timescale 1ns/1ps
module ccrc_board_model (
  input  wire logic        clk,
  input  wire logic [3:0]  strapReq,
  input  wire logic [31:0] dataReq,
  output logic      [3:0]  clockRatioSelectPins,
  output logic      [31:0] busIn
);
  // -------------------------------------------------------------
  // straps and data
  // -------------------------------------------------------------
  // straps follow the bench request one clock later, on every rising clock edge
  always_ff @(posedge clk) begin
    clockRatioSelectPins <= strapReq;
  end
  // bus data launched on the reference clock, which never stops
  always_ff @(posedge clk) begin
    busIn <= dataReq;
  end
endmodule : ccrc_board_model

/* File: sim/ccrc_top_tb.sv */
// self-checking bench for the clock ratio configuration block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samplesChecked++; if ((gt) !== (ex)) begin \
  $display("FAIL %s expected %h seen %h", nm, ex, gt); numErrors++; end end
module ccrc_top_tb;
  logic        clk;
  logic        srst;
  logic [3:0]  strapReq;
  logic [31:0] dataReq;
  logic [3:0]  clockRatioSelectPins;
  logic [31:0] busIn;
  logic [31:0] busOut;
  logic        busClkOut;
  logic        testClkOut;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          numErrors;
  int          samplesChecked;
  int          nTest;
  int          nBus;
  logic [31:0] rd;

  // -------------------------------------------------------------
  // instances and clock
  // -------------------------------------------------------------
  ccrc_top u_ccrc_top (.clk(clk), .srst(srst), .clockRatioSelectPins(clockRatioSelectPins),
    .busIn(busIn), .busOut(busOut), .busClkOut(busClkOut), .testClkOut(testClkOut),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ccrc_board_model u_ccrc_board_model (.clk(clk), .strapReq(strapReq), .dataReq(dataReq),
    .clockRatioSelectPins(clockRatioSelectPins), .busIn(busIn));

  // free running reference clock, 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic stopTest();
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stopTest

  // reset with new straps, then wait for the latch
  task automatic resetDut(input logic [3:0] c);
    @(posedge clk);
    srst     <= 1'b1;
    strapReq <= c;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (ccrc_pkg::SETTLE_CYC + 4) @(posedge clk);
  endtask : resetDut

  // one avalon access, held until waitrequest is seen low
  task automatic avXfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      numErrors++;
      stopTest();
    end
  endtask : avXfer

  // rising edges of both clock outputs over four bus frames
  task automatic countRises();
    logic pt;
    logic pb;
    nTest = 0;
    nBus  = 0;
    @(posedge clk);
    pt = testClkOut;
    pb = busClkOut;
    repeat (48) begin
      @(posedge clk);
      if (testClkOut === 1'b1 && pt === 1'b0) nTest++;
      if (busClkOut === 1'b1 && pb === 1'b0) nBus++;
      pt = testClkOut;
      pb = busClkOut;
    end
  endtask : countRises

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  // every strap code: status fields and clock rates
  task automatic testCodes();
    logic [3:0] c;
    logic       ok;
    logic       byp;
    logic       off;
    int         expT;
    for (int i = 0; i < 16; i++) begin
      c   = i[3:0];
      ok  = c inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'hc};
      byp = (c == 4'h3);
      off = (c == 4'hf);
      expT = 0;
      if (byp) expT = 4;
      if (ok) expT = (c[3:2] == 2'h0) ? 4 : (c[3:2] == 2'h1) ? 8 : (c[3:2] == 2'h2) ? 12 : 6;
      resetDut(c);
      avXfer(1'b0, ccrc_pkg::OFS_STATUS, 32'h0, 4'hf, rd);
      `CHK("code", c, rd[3:0])
      `CHK("bypass", byp, rd[ccrc_pkg::ST_BYPASS])
      `CHK("clkoff", off, rd[ccrc_pkg::ST_OFF])
      `CHK("unsup", !(ok || byp || off), rd[ccrc_pkg::ST_UNSUP])
      if (ok) begin
        `CHK("ratio", c[3:2], rd[5:4])
        `CHK("mult", c[1:0], rd[7:6])
        `CHK("valid", 1'b1, rd[ccrc_pkg::ST_VALID])
      end
      countRises();
      `CHK("coreRises", expT, nTest)
      `CHK("busRises", (ok || byp) ? 4 : 0, nBus)
    end
  endtask : testCodes

  // test clock gate and its reset value
  task automatic testCtrl();
    resetDut(4'h4);
    avXfer(1'b0, ccrc_pkg::OFS_CTRL, 32'h0, 4'hf, rd);
    `CHK("ctrlRst", ccrc_pkg::CTRL_RST, rd[ccrc_pkg::CTRL_TCLK_EN])
    avXfer(1'b1, ccrc_pkg::OFS_CTRL, 32'h0, 4'h1, rd);
    countRises();
    `CHK("gatedRises", 0, nTest)
    avXfer(1'b1, ccrc_pkg::OFS_CTRL, 32'h1, 4'h1, rd);
    repeat (2) @(posedge clk);
    countRises();
    `CHK("testRises", 8, nTest)
  endtask : testCtrl

  // bus data moves only on a bus tick, never in clock-off
  task automatic testBus(input logic [3:0] c, input int expChg);
    int         chg;
    logic [31:0] p;
    resetDut(c);
    dataReq <= 32'h5a3c_96e1;
    avXfer(1'b1, ccrc_pkg::OFS_TXDATA, 32'hc0de_1234, 4'hf, rd);
    chg = 0;
    p   = busOut;
    repeat (30) begin
      @(posedge clk);
      if (busOut !== p) chg++;
      p = busOut;
    end
    `CHK("busOutChanges", expChg, chg)
    if (expChg == 1) begin
      `CHK("busOut", 32'hc0de_1234, busOut)
      avXfer(1'b0, ccrc_pkg::OFS_RXDATA, 32'h0, 4'hf, rd);
      `CHK("rxData", 32'h5a3c_96e1, rd)
    end
  endtask : testBus

  // unmapped and read-only places, pins moved while running
  task automatic testRegs();
    resetDut(4'h1);
    avXfer(1'b0, 5'h14, 32'h0, 4'hf, rd);
    `CHK("unmapped", 32'h0, rd)
    avXfer(1'b1, ccrc_pkg::OFS_STATUS, 32'hffff_efff, 4'hf, rd);
    strapReq <= 4'h8;
    repeat (10) @(posedge clk);
    avXfer(1'b0, ccrc_pkg::OFS_STATUS, 32'h0, 4'hf, rd);
    `CHK("codeHeld", 4'h1, rd[3:0])
    `CHK("pinChg", 1'b1, rd[ccrc_pkg::ST_PINCHG])
    countRises();
    `CHK("rateHeld", 4, nTest)
    strapReq <= 4'h1;
    repeat (4) @(posedge clk);
    avXfer(1'b1, ccrc_pkg::OFS_STATUS, 32'h0000_1000, 4'h2, rd);
    avXfer(1'b0, ccrc_pkg::OFS_STATUS, 32'h0, 4'hf, rd);
    `CHK("pinClr", 1'b0, rd[ccrc_pkg::ST_PINCHG])
  endtask : testRegs

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    numErrors      = 0;
    samplesChecked = 0;
    srst           = 1'b1;
    strapReq       = 4'h0;
    dataReq        = 32'h0;
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
    testCodes();
    testCtrl();
    testBus(4'h8, 1);
    testBus(4'hf, 0);
    testRegs();
    stopTest();
  end
endmodule : ccrc_top_tb

/* File: verilog/ccrc_phase_gen.sv */
// makes bus and core clock phases from the reference clock
`timescale 1ns/1ps
module ccrc_phase_gen (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic run,
  ccrc_cfg_if.gen   cfg,
  output logic      busRise,
  output logic      coreRise,
  output logic      coreClk,
  output logic      busClk
);
  logic [3:0] frameCntFf;
  logic [2:0] halfCntFf;
  logic [2:0] halfLast;
  logic       oddFrameFf;
  logic       active;

  // ---------------------------------------------------------------
  // half period of the core clock per ratio
  // ---------------------------------------------------------------
  always_comb begin
    active = run && !cfg.clkOff && !cfg.unsup;               // RULE6 RULE12
    unique case (cfg.ratio)
      ccrc_pkg::RATIO_1_1: halfLast = 3'(ccrc_pkg::HALF_1_1 - 1);
      ccrc_pkg::RATIO_2_1: halfLast = 3'(ccrc_pkg::HALF_2_1 - 1);
      ccrc_pkg::RATIO_3_1: halfLast = 3'(ccrc_pkg::HALF_3_1 - 1);
      ccrc_pkg::RATIO_3_2: halfLast = 3'(ccrc_pkg::HALF_3_2 - 1);
    endcase
  end

  // frame counter, one bus period per frame, with frame parity
  always_ff @(posedge clk) begin
    if (srst || !active) begin
      frameCntFf <= 4'h0;
      oddFrameFf <= 1'b0;
      busClk     <= 1'b0;
      busRise    <= 1'b0;
    end else begin
      frameCntFf <= (frameCntFf == 4'(ccrc_pkg::FRAME_CYC - 1)) ? 4'h0 : frameCntFf + 4'h1;
      if (frameCntFf == 4'(ccrc_pkg::FRAME_CYC - 1)) begin
        oddFrameFf <= !oddFrameFf;   // 1.5:1 only meets the bus every second frame
      end
      busRise    <= (frameCntFf == 4'h0);                                  // RULE9
      busClk     <= (frameCntFf < 4'(ccrc_pkg::FRAME_CYC / 2));
    end
  end

  // core clock, realigned every second bus frame where all ratios meet
  always_ff @(posedge clk) begin
    if (srst || !active) begin
      halfCntFf <= 3'h0;
      coreClk   <= 1'b0;
      coreRise  <= 1'b0;
    end else if (frameCntFf == 4'h0 && !oddFrameFf) begin
      halfCntFf <= 3'h0;
      coreClk   <= 1'b1;
      coreRise  <= 1'b1;
    end else if (halfCntFf == halfLast) begin
      halfCntFf <= 3'h0;
      coreClk   <= !coreClk;                                               // RULE9
      coreRise  <= !coreClk;
    end else begin
      halfCntFf <= halfCntFf + 3'h1;
      coreRise  <= 1'b0;
    end
  end
endmodule : ccrc_phase_gen

/* File: verilog/ccrc_ratio_decode.sv */
// decodes the latched select code into ratio, multiplier and mode
`timescale 1ns/1ps
module ccrc_ratio_decode (
  input  wire logic [3:0] code,
  ccrc_cfg_if.dec         cfg
);
  // ---------------------------------------------------------------
  // field split and legal code check
  // ---------------------------------------------------------------
  always_comb begin
    cfg.mult   = code[1:0];          // RULE7
    cfg.bypass = 1'b0;
    cfg.clkOff = 1'b0;
    cfg.unsup  = 1'b0;
    unique case (code[3:2])          // RULE7
      ccrc_pkg::RF_1_1: cfg.ratio = ccrc_pkg::RATIO_1_1;   // RULE3
      ccrc_pkg::RF_2_1: cfg.ratio = ccrc_pkg::RATIO_2_1;   // RULE4
      ccrc_pkg::RF_3_1: cfg.ratio = ccrc_pkg::RATIO_3_1;   // RULE4
      ccrc_pkg::RF_3_2: cfg.ratio = ccrc_pkg::RATIO_3_2;   // RULE4
    endcase
    if (code == ccrc_pkg::CODE_BYPASS) begin
      cfg.ratio  = ccrc_pkg::RATIO_1_1;                    // RULE5
      cfg.bypass = 1'b1;
    end else if (code == ccrc_pkg::CODE_OFF) begin
      cfg.clkOff = 1'b1;                                   // RULE6
    end else begin
      unique case (code)
        4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'hc: cfg.unsup = 1'b0;
        default: cfg.unsup = 1'b1;                         // RULE12
      endcase
    end
  end
endmodule : ccrc_ratio_decode

/* File: verilog/ccrc_top.sv */
// top of the core clock ratio configuration block
//
// Summary of operation
// RULE1: test clock output toggles at core rate
// RULE2: board keeps select pins steady while running
// RULE3: codes 0000 to 0010 give 1:1
// RULE4: 0100/0101 2:1, 1000 3:1, 1100 1.5:1
// RULE5: code 0011 bypasses, core equals bus clock
// RULE6: clock-off mode makes no internal clocks
// RULE7: upper pins ratio, lower pins multiplier
// RULE8: board keeps PLL between 100 and 200 MHz
// RULE9: bus at core, half, third, two thirds
// RULE10: bus in/out only on bus rising edge
// RULE11: board keeps reference clock steady
// RULE12: unlisted codes are unsupported, no clocks
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module ccrc_top #(
  parameter int BUS_W = 32
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [3:0]       clockRatioSelectPins,
  input  wire logic [BUS_W-1:0] busIn,
  output logic      [BUS_W-1:0] busOut,
  output logic                  busClkOut,
  output logic                  testClkOut,
  input  wire logic [4:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest
);
  typedef enum {CFG_SETTLE, CFG_RUN} ccrc_cfg_e;

  ccrc_cfg_e        stateFf;
  logic [3:0]       selMetaFf;
  logic [3:0]       selSyncFf;
  logic [BUS_W-1:0] inMetaFf;
  logic [BUS_W-1:0] inSyncFf;
  logic [3:0]       codeFf;
  logic [3:0]       settleCntFf;
  logic             pinChgFf;
  logic             tclkEnFf;
  logic [31:0]      txDataFf;
  logic [BUS_W-1:0] rxDataFf;
  logic [31:0]      coreCntFf;
  logic             run;
  logic             busRise;
  logic             coreRise;
  logic             coreClk;
  logic             busClk;
  logic             take;
  logic             wrStatus;
  logic [31:0]      statusWord;
  logic [31:0]      rdMux;

  ccrc_cfg_if cfgIf ();

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      selMetaFf <= 4'h0;
      selSyncFf <= 4'h0;
    end else begin
      selMetaFf <= clockRatioSelectPins;
      selSyncFf <= selMetaFf;
    end
  end

  // bus input synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      inMetaFf <= '0;
      inSyncFf <= '0;
    end else begin
      inMetaFf <= busIn;
      inSyncFf <= inMetaFf;
    end
  end

  // ---------------------------------------------------------------
  // strap capture after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      stateFf     <= CFG_SETTLE;
      settleCntFf <= 4'h0;
      codeFf      <= 4'h0;
    end else begin
      unique case (stateFf)
        CFG_SETTLE: begin
          settleCntFf <= settleCntFf + 4'h1;
          if (settleCntFf == 4'(ccrc_pkg::SETTLE_CYC - 1)) begin
            codeFf  <= selSyncFf;   // straps read once, held for the run
            stateFf <= CFG_RUN;
          end
        end
        CFG_RUN: stateFf <= CFG_RUN;
      endcase
    end
  end

  assign run = (stateFf == CFG_RUN);

  // pins moving while running are flagged, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      pinChgFf <= 1'b0;
    end else if (run && selSyncFf != codeFf) begin
      pinChgFf <= 1'b1;                                   // RULE2
    end else if (wrStatus && avs_byteenable[1] && avs_writedata[ccrc_pkg::ST_PINCHG]) begin
      pinChgFf <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // decode and phase generation
  // ---------------------------------------------------------------
  ccrc_ratio_decode u_dec (
    .code (codeFf),
    .cfg  (cfgIf.dec)
  );

  ccrc_phase_gen u_gen (
    .clk      (clk),
    .srst     (srst),
    .run      (run),
    .cfg      (cfgIf.gen),
    .busRise  (busRise),
    .coreRise (coreRise),
    .coreClk  (coreClk),
    .busClk   (busClk)
  );

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      testClkOut <= 1'b0;
      busClkOut  <= 1'b0;
    end else begin
      testClkOut <= coreClk && tclkEnFf;                  // RULE1
      busClkOut  <= busClk;
    end
  end

  // bus data moves only at the bus rising edge
  always_ff @(posedge clk) begin
    if (srst) begin
      busOut   <= '0;
      rxDataFf <= '0;
    end else if (busRise) begin
      busOut   <= txDataFf[BUS_W-1:0];                    // RULE10
      rxDataFf <= inSyncFf;                               // RULE10
    end
  end

  // core activity counter, shows the core clock runs
  always_ff @(posedge clk) begin
    if (srst) begin
      coreCntFf <= 32'h0;
    end else if (coreRise) begin
      coreCntFf <= coreCntFf + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // avalon slave, one wait cycle per access
  // ---------------------------------------------------------------
  assign take     = (avs_read || avs_write) && !avs_waitrequest;
  assign wrStatus = take && avs_write && avs_address == ccrc_pkg::OFS_STATUS;

  always_comb begin
    statusWord = 32'h0;
    statusWord[3:0]                 = codeFf;
    statusWord[5:4]                 = 2'(cfgIf.ratio);
    statusWord[7:6]                 = cfgIf.mult;
    statusWord[ccrc_pkg::ST_BYPASS] = cfgIf.bypass;
    statusWord[ccrc_pkg::ST_OFF]    = cfgIf.clkOff;
    statusWord[ccrc_pkg::ST_UNSUP]  = cfgIf.unsup;
    statusWord[ccrc_pkg::ST_VALID]  = run;
    statusWord[ccrc_pkg::ST_PINCHG] = pinChgFf;
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rdMux = 32'h0;
    unique case (avs_address)
      ccrc_pkg::OFS_CTRL:    rdMux[ccrc_pkg::CTRL_TCLK_EN] = tclkEnFf;
      ccrc_pkg::OFS_STATUS:  rdMux = statusWord;
      ccrc_pkg::OFS_TXDATA:  rdMux = txDataFf;
      ccrc_pkg::OFS_RXDATA:  rdMux[BUS_W-1:0] = rxDataFf;
      ccrc_pkg::OFS_CORECNT: rdMux = coreCntFf;
      default:               rdMux = 32'h0;
    endcase
  end

  // waitrequest drops for one cycle after a request shows
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rdMux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // writable registers with byte lanes
  always_ff @(posedge clk) begin
    if (srst) begin
      tclkEnFf <= ccrc_pkg::CTRL_RST;
      txDataFf <= 32'h0;
    end else if (take && avs_write) begin
      if (avs_address == ccrc_pkg::OFS_CTRL && avs_byteenable[0]) begin
        tclkEnFf <= avs_writedata[ccrc_pkg::CTRL_TCLK_EN];
      end
      if (avs_address == ccrc_pkg::OFS_TXDATA) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            txDataFf[b*8 +: 8] <= avs_writedata[b*8 +: 8];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_test_clk_follow: assert property (                    // RULE1
    coreRise && tclkEnFf |=> testClkOut)
    else $error("test clock did not follow core clock");

  a_one_to_one: assert property (                         // RULE3
    run && codeFf inside {4'h0, 4'h1, 4'h2} |-> cfgIf.ratio == ccrc_pkg::RATIO_1_1)
    else $error("codes 0 to 2 must give 1:1");

  a_ratio_map: assert property (                          // RULE4
    run |-> (!(codeFf inside {4'h4, 4'h5}) || cfgIf.ratio == ccrc_pkg::RATIO_2_1)
      && (codeFf != 4'h8 || cfgIf.ratio == ccrc_pkg::RATIO_3_1)
      && (codeFf != 4'hc || cfgIf.ratio == ccrc_pkg::RATIO_3_2))
    else $error("ratio code mapping wrong");

  a_bypass_mode: assert property (                        // RULE5
    run && codeFf == ccrc_pkg::CODE_BYPASS && busRise |->
      coreRise ##1 !coreRise [*5] ##1 !coreRise ##6 coreRise)
    else $error("bypass core clock not equal to bus clock");

  a_clock_off: assert property (                          // RULE6
    cfgIf.clkOff |-> !coreRise && !busRise && !busClkOut ##1 !testClkOut)
    else $error("clock activity in clock-off mode");

  a_mult_field: assert property (                         // RULE7
    !cfgIf.unsup && !cfgIf.bypass && !cfgIf.clkOff |->
      cfgIf.mult == codeFf[1:0] && cfgIf.mult != 2'h3)
    else $error("multiplier field wrong");

  a_bus_period: assert property (                         // RULE9
    busRise && run && !cfgIf.unsup |=> !busRise [*8] ##1 !busRise [*3] ##1 busRise)
    else $error("bus period not twelve cycles");

  a_core_half: assert property (                          // RULE9
    coreRise && cfgIf.ratio == ccrc_pkg::RATIO_2_1 |-> ##6 coreRise)
    else $error("2:1 core period not six cycles");

  a_core_third: assert property (                         // RULE9
    coreRise && cfgIf.ratio == ccrc_pkg::RATIO_3_1 |-> ##4 coreRise)
    else $error("3:1 core period not four cycles");

  a_core_full: assert property (                          // RULE3
    coreRise && cfgIf.ratio == ccrc_pkg::RATIO_1_1 |-> ##12 coreRise)
    else $error("1:1 core period not twelve cycles");

  a_core_two_thirds: assert property (                    // RULE9
    coreRise && cfgIf.ratio == ccrc_pkg::RATIO_3_2 |-> ##8 coreRise)
    else $error("1.5:1 core period not eight cycles");

  a_quiet_settle: assert property (
    !run |-> !busRise && !coreRise && !testClkOut)
    else $error("clock activity before straps latched");

  a_bus_edge_io: assert property (                        // RULE10
    $changed(busOut) || $changed(rxDataFf) |-> $past(busRise))
    else $error("bus data moved off the bus edge");

  a_unsup_code: assert property (                         // RULE12
    run && cfgIf.unsup |-> !coreRise && !busRise ##1 coreCntFf == $past(coreCntFf))
    else $error("clocks ran on an unsupported code");

  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not one cycle low");
endmodule : ccrc_top
